// File: eitmr_top.v
/*
 Eight-bit interval timer group: timers 8, 9, A, B behind an APB slave.
 Assumes clock sources low_speed_clock, high_speed_timebase_clock and
 the external pins are levels synchronous to pclk.
*/
// Decided for this implementation: the APB slave port.
// How it works
// - Run write sets status on first clock fall, counting starts on second
// - Match raises interrupt next fall and clears counter, counting continues
// - Each match inverts the toggle output of timers 9 and B
// - Toggle output is zero after reset and equals the polarity bit while stopped outside cascade mode
// - After run cleared, one more fall counts, then status clears
// - Restart resumes from held count without clearing
// - Any write to the count register clears the count
// - Interrupt period is compare plus one timer clocks
// - Only first period after start may be off by one clock
// - One-shot mode clears run bit on match
// - Upper timer increments on lower overflow regardless of its run bit
// - Upper timer status reads zero in cascade mode
// - Run control: bit 0 run, bit 7 read-only status
// - Clock select: low, high, idle, external
// - Cascade joins pairs and silences the lower interrupt
// - Polarity bit sets toggle output logic and initial level
`timescale 1ns/1ps
`default_nettype none
`include "eitmr_consts.vh"
module eitmr_top
#(
    parameter NCH = 4
)
(
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Timer clock sources
    input wire low_speed_clock,
    input wire high_speed_timebase_clock,
    input wire [NCH-1:0] ext_clock,
    // Events and outputs
    output reg [NCH-1:0] match_interrupt,
    output reg timer9_toggle_output,
    output reg timerb_toggle_output
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg [NCH-1:0] run_bit;
    reg [7:0] cfg [0:NCH-1];
    reg [7:0] cmp [0:NCH-1];
    wire [7:0] cnt [0:NCH-1];
    wire [NCH-1:0] counting_flag;
    wire [NCH-1:0] irq;
    wire [NCH-1:0] ovf;
    wire [NCH-1:0] rclr;
    wire [NCH-1:0] tog;
    wire low_fall;
    wire high_fall;
    wire [NCH-1:0] ext_fall;
    reg [NCH-1:0] tick;
    reg [NCH-1:0] cnt_wr;
    reg [2:0] sel;
    reg [1:0] kind;
    reg hit_map;
    integer k;

    // Cascade bits live in timer 8 and timer A first controls
    wire casc89 = cfg[0][`EITMR_CASCADE_BIT];
    wire cascab = cfg[2][`EITMR_CASCADE_BIT];
    wire access = psel & penable & ~pready;

    ////////////////////////////////////////////////////////////////////////
    // Edge detection of shared and per-channel sources
    eitmr_edge u_low
    (
        .pclk(pclk),
        .presetn(presetn),
        .level(low_speed_clock),
        .fall(low_fall)
    );
    eitmr_edge u_high
    (
        .pclk(pclk),
        .presetn(presetn),
        .level(high_speed_timebase_clock),
        .fall(high_fall)
    );

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            eitmr_edge u_ext
            (
                .pclk(pclk),
                .presetn(presetn),
                .level(ext_clock[g]),
                .fall(ext_fall[g])
            );
            // Odd channels are upper halves of a pair
            eitmr_chan #(.WIDTH(8)) u_chan
            (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick[g]),
                .run_bit(run_bit[g]),
                .upper_mode((g % 2 == 1) ? ((g < 2) ? casc89 : cascab) : 1'b0),
                .carry_in((g % 2 == 1) ? ovf[g-1 + (g % 2 == 0)] : 1'b0),
                .no_irq((g % 2 == 0) ? ((g < 2) ? casc89 : cascab) : 1'b0),
                .one_shot(cfg[g][`EITMR_ONESHOT_BIT]),
                .neg(cfg[g][`EITMR_NEG_BIT]),
                .cnt_wr(cnt_wr[g]),
                .compare_value(cmp[g]),
                .count_value(cnt[g]),
                .counting_flag(counting_flag[g]),
                .match_interrupt(irq[g]),
                .overflow(ovf[g]),
                .run_clear(rclr[g]),
                .toggle_output(tog[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Clock select per channel
    always @*
    begin
        for (k = 0; k < NCH; k = k + 1)
        begin
            case (cfg[k][1:0])
                `EITMR_CS_LOW: tick[k] = low_fall;
                `EITMR_CS_HIGH: tick[k] = high_fall;
                `EITMR_CS_EXT: tick[k] = ext_fall[k];
                default: tick[k] = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode: sel is channel, kind is register type
    always @*
    begin
        sel = 3'h0;
        kind = 2'h0;
        hit_map = 1'b1;
        case (paddr)
            `EITMR_T8_RUN_CTRL:
            begin
                sel = 3'h0;
                kind = 2'h0;
            end
            `EITMR_T9_RUN_CTRL:
            begin
                sel = 3'h1;
                kind = 2'h0;
            end
            `EITMR_TA_RUN_CTRL:
            begin
                sel = 3'h2;
                kind = 2'h0;
            end
            `EITMR_TB_RUN_CTRL:
            begin
                sel = 3'h3;
                kind = 2'h0;
            end
            `EITMR_T8_CFG:
            begin
                sel = 3'h0;
                kind = 2'h1;
            end
            `EITMR_T9_CFG:
            begin
                sel = 3'h1;
                kind = 2'h1;
            end
            `EITMR_TA_CFG:
            begin
                sel = 3'h2;
                kind = 2'h1;
            end
            `EITMR_TB_CFG:
            begin
                sel = 3'h3;
                kind = 2'h1;
            end
            `EITMR_T8_CMP:
            begin
                sel = 3'h0;
                kind = 2'h2;
            end
            `EITMR_T9_CMP:
            begin
                sel = 3'h1;
                kind = 2'h2;
            end
            `EITMR_TA_CMP:
            begin
                sel = 3'h2;
                kind = 2'h2;
            end
            `EITMR_TB_CMP:
            begin
                sel = 3'h3;
                kind = 2'h2;
            end
            `EITMR_T8_CNT:
            begin
                sel = 3'h0;
                kind = 2'h3;
            end
            `EITMR_T9_CNT:
            begin
                sel = 3'h1;
                kind = 2'h3;
            end
            `EITMR_TA_CNT:
            begin
                sel = 3'h2;
                kind = 2'h3;
            end
            `EITMR_TB_CNT:
            begin
                sel = 3'h3;
                kind = 2'h3;
            end
            // Unmapped: answered with an error, nothing written
            default: hit_map = 1'b0;
        endcase
    end

    // Count register write strobe, one cycle
    always @*
    begin
        cnt_wr = {NCH{1'b0}};
        if (access && pwrite && hit_map && kind == 2'h3)
            cnt_wr[sel[1:0]] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer in the second access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            run_bit <= {NCH{1'b0}};
            for (k = 0; k < NCH; k = k + 1)
            begin
                cfg[k] <= `EITMR_CFG_RESET;
                cmp[k] <= `EITMR_CMP_RESET;
            end
        end
        else
        begin
            pready <= access;
            pslverr <= access & ~hit_map;
            // One-shot match drops the run bit
            run_bit <= run_bit & ~rclr;
            if (access && pwrite && hit_map)
            begin
                case (kind)
                    2'h0: run_bit[sel[1:0]] <= pwdata[`EITMR_RUN_BIT];
                    2'h1: cfg[sel[1:0]] <= pwdata[7:0];
                    2'h2: cmp[sel[1:0]] <= pwdata[7:0];
                    default: ;
                endcase
            end
            if (access && !pwrite && hit_map)
            begin
                case (kind)
                    2'h0: prdata <= {24'h000000, counting_flag[sel[1:0]], 6'h00,
                        run_bit[sel[1:0]]};
                    2'h1: prdata <= {24'h000000, cfg[sel[1:0]]};
                    2'h2: prdata <= {24'h000000, cmp[sel[1:0]]};
                    default: prdata <= {24'h000000, cnt[sel[1:0]]};
                endcase
            end
            else if (access)
                prdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered event and pin outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_interrupt <= {NCH{1'b0}};
            timer9_toggle_output <= 1'b0;
            timerb_toggle_output <= 1'b0;
        end
        else
        begin
            match_interrupt <= irq;
            timer9_toggle_output <= tog[1];
            timerb_toggle_output <= tog[3];
        end
    end
endmodule // eitmr_top
`default_nettype wire

// File: eitmr_consts.vh
/*
 Register offsets, field positions, clock select encodings and reset values of
 the eight-bit interval timer group.
 Assumes inclusion by the timer RTL files by bare name.
*/
`ifndef EITMR_CONSTS_VH
`define EITMR_CONSTS_VH

// Run control registers, printed byte addresses
`define EITMR_T9_RUN_CTRL 16'hF8E7
`define EITMR_TA_RUN_CTRL 16'hF8EB
`define EITMR_TB_RUN_CTRL 16'hF8EF
`define EITMR_T8_RUN_CTRL 16'hF8E3
// First control registers (clock select, mode bits)
`define EITMR_T8_CFG 16'hF8E2
`define EITMR_T9_CFG 16'hF8E6
`define EITMR_TA_CFG 16'hF8EA
`define EITMR_TB_CFG 16'hF8EE
// Compare value and count value registers
`define EITMR_T8_CMP 16'hF8E0
`define EITMR_T9_CMP 16'hF8E4
`define EITMR_TA_CMP 16'hF8E8
`define EITMR_TB_CMP 16'hF8EC
`define EITMR_T8_CNT 16'hF8F0
`define EITMR_T9_CNT 16'hF8F4
`define EITMR_TA_CNT 16'hF8F8
`define EITMR_TB_CNT 16'hF8FC
// Field positions
`define EITMR_RUN_BIT 0
`define EITMR_STAT_BIT 7
`define EITMR_CASCADE_BIT 2
`define EITMR_NEG_BIT 6
`define EITMR_ONESHOT_BIT 7
// Clock select encodings
`define EITMR_CS_LOW 2'h0
`define EITMR_CS_HIGH 2'h1
`define EITMR_CS_OFF 2'h2
`define EITMR_CS_EXT 2'h3
// Reset values
`define EITMR_CMP_RESET 8'hFF
`define EITMR_CFG_RESET 8'h00

`endif

// File: eitmr_edge.v
/*
 Falling edge detector for one timer clock source.
 Assumes the clock source is synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module eitmr_edge
(
    // System
    input wire pclk,
    input wire presetn,
    // Source
    input wire level,
    output wire fall
);
    reg last;

    // Remember previous level
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last <= 1'b0;
        else
            last <= level;
    end

    assign fall = last & ~level;
endmodule // eitmr_edge
`default_nettype wire

// File: eitmr_chan.v
/*
 One eight-bit timer channel: run/status handshake, compare, interrupt,
 toggle output, one-shot and cascade increment.
 Assumes tick is a one-cycle pulse per selected timer clock falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module eitmr_chan
#(
    parameter WIDTH = 8
)
(
    // System
    input wire pclk,
    input wire presetn,
    // Control
    input wire tick,
    input wire run_bit,
    input wire upper_mode,
    input wire carry_in,
    input wire no_irq,
    input wire one_shot,
    input wire neg,
    input wire cnt_wr,
    input wire [WIDTH-1:0] compare_value,
    // State
    output reg [WIDTH-1:0] count_value,
    output reg counting_flag,
    output reg match_interrupt,
    output reg overflow,
    output reg run_clear,
    output reg toggle_output
);
    wire step;
    wire hit;
    reg tog;

    // Upper half steps on the lower carry, not on its own clock
    assign step = upper_mode ? carry_in : (tick & counting_flag);
    assign hit = (count_value == compare_value);

    // Counting, match and output state
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_value <= {WIDTH{1'b0}};
            counting_flag <= 1'b0;
            match_interrupt <= 1'b0;
            overflow <= 1'b0;
            run_clear <= 1'b0;
            tog <= 1'b0;
            toggle_output <= 1'b0;
        end
        else
        begin
            match_interrupt <= 1'b0;
            overflow <= 1'b0;
            run_clear <= 1'b0;
            // Status follows run on a timer clock edge; last edge still counts
            if (upper_mode)
                counting_flag <= 1'b0;
            else if (tick)
                counting_flag <= run_bit;
            if (cnt_wr)
                count_value <= {WIDTH{1'b0}};
            else if (step)
            begin
                if (hit)
                begin
                    count_value <= {WIDTH{1'b0}};
                    match_interrupt <= ~no_irq;
                    overflow <= 1'b1;
                    tog <= ~tog;
                    run_clear <= one_shot;
                end
                else
                    count_value <= count_value + 1'b1;
            end
            // Output idles at its stopped level
            if (!counting_flag && !upper_mode && !run_bit)
                tog <= 1'b0;
            toggle_output <= tog ^ neg;
        end
    end
endmodule // eitmr_chan
`default_nettype wire

// File: eitmr_props.sv
/*
 Port checker for the interval timer group: bus answer and event timing.
 Assumes it is bound onto eitmr_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module eitmr_props
#(
    parameter NCH = 4
)
(
    // Bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Timer side
    input wire low_speed_clock,
    input wire high_speed_timebase_clock,
    input wire [NCH-1:0] ext_clock,
    input wire [NCH-1:0] match_interrupt,
    input wire timer9_toggle_output,
    input wire timerb_toggle_output
);
    reg [NCH+1:0] src_q;
    reg [3:0] age_fall;
    reg [3:0] age_acc;
    wire [NCH+1:0] src = {ext_clock, high_speed_timebase_clock, low_speed_clock};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Saturating ages, so events need a recent clock fall or access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_q <= {(NCH+2){1'b0}};
            age_fall <= 4'hF;
            age_acc <= 4'hF;
        end
        else
        begin
            src_q <= src;
            age_fall <= |(src_q & ~src) ? 4'h0 : age_fall + {3'h0, age_fall != 4'hF};
            age_acc <= pready ? 4'h0 : age_acc + {3'h0, age_acc != 4'hF};
        end
    end
    property p_ready_wait;
        psel && penable && !pready && !$past(penable) |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("no answer after one wait");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_ready_cause;
        pready |-> psel && penable;
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
    property p_idle_ready;
        !psel |=> !pready;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("ready while idle");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("bad error answer");
    property p_irq_pulse;
        |match_interrupt |=> (match_interrupt & $past(match_interrupt)) == {NCH{1'b0}};
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
    property p_irq_cause;
        |match_interrupt |-> age_fall <= 4'h8;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without tick");
    property p_tog_cause;
        $changed({timer9_toggle_output, timerb_toggle_output}) |-> age_fall <= 4'h8 || age_acc <= 4'h8;
    endproperty
    a_tog_cause: assert property (p_tog_cause) else $error("toggle without cause");
endmodule // eitmr_props
bind eitmr_top eitmr_props #(.NCH(NCH)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_clock(low_speed_clock), .high_speed_timebase_clock(high_speed_timebase_clock),
    .ext_clock(ext_clock), .match_interrupt(match_interrupt),
    .timer9_toggle_output(timer9_toggle_output), .timerb_toggle_output(timerb_toggle_output));
`default_nettype wire

// File: tb.sv
/*
 Self-checking bench for the timer group over APB.
 Assumes the one-wait-state slave and register map of eitmr_consts.vh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eitmr_consts.vh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic low_speed_clock = 1'b0;
    logic high_speed_timebase_clock = 1'b0;
    logic [3:0] ext_clock = 4'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [3:0] match_interrupt;
    wire tog9;
    wire togb;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    int per[4] = '{32, 8, 0, 12};
    int t1, t2, t3, k;
    logic [31:0] rd;
    logic er, g;
    eitmr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_speed_clock(low_speed_clock),
        .high_speed_timebase_clock(high_speed_timebase_clock), .ext_clock(ext_clock),
        .match_interrupt(match_interrupt), .timer9_toggle_output(tog9),
        .timerb_toggle_output(togb));
    initial
        forever #5 pclk = ~pclk;
    // Timer sources: periods 32, 8 and 12 pclk, all in step with pclk
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        low_speed_clock <= cyc[4];
        high_speed_timebase_clock <= cyc[2];
        ext_clock <= {4{cyc % 12 < 6}};
    end
    ////////////////////////////////////////////////////////////////////
    task conclude;
        begin
            if (failures == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_tests++;
            if (seen !== exp)
            begin
                failures++;
                $display("unexpected %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (pready !== 1'b1 && n < 20);
            rd = prdata;
            er = pslverr;
            if (pready !== 1'b1)
            begin
                failures++;
                conclude;
            end
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // Cycle of the next interrupt pulse, or -1 when none comes
    task wirq(input int b, input int lim, output int t);
        begin
            t = -1;
            repeat (lim)
                if (t < 0)
                begin
                    @(posedge pclk);
                    if (match_interrupt[b] === 1'b1)
                        t = cyc;
                end
        end
    endtask
    // Stop, then poll the status bit before treating the timer as halted
    task stop(input logic [15:0] a);
        int n;
        begin
            xfer(1'b1, a, 32'h0);
            n = 0;
            do
            begin
                xfer(1'b0, a, 32'h0);
                n++;
            end
            while (rd[7] !== 1'b0 && n < 30);
            chk("stopped control", rd, 32'h0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, `EITMR_T9_RUN_CTRL, 32'h0);
        chk("run control reset", rd, 32'h0);
        xfer(1'b0, `EITMR_T9_CMP, 32'h0);
        chk("compare reset", rd, 32'hFF);
        xfer(1'b0, 16'h1234, 32'h0);
        chk("unmapped answer", {rd[30:0], er}, 32'h1);
        xfer(1'b1, `EITMR_T9_RUN_CTRL, 32'hFE);
        xfer(1'b0, `EITMR_T9_RUN_CTRL, 32'h0);
        chk("fixed bits", rd, 32'h0);
        // Every clock select on timer 8, compare 1
        for (k = 0; k < 4; k++)
        begin
            xfer(1'b1, `EITMR_T8_CFG, k);
            xfer(1'b1, `EITMR_T8_CMP, 32'h1);
            xfer(1'b1, `EITMR_T8_RUN_CTRL, 32'h1);
            wirq(0, 200, t1);
            wirq(0, 200, t2);
            wirq(0, 200, t3);
            if (k == 2)
                chk("idle select", t1, 32'hFFFFFFFF);
            else
            begin
                chk("first period", t2 - t1, 2 * per[k]);
                chk("later period", t3 - t2, 2 * per[k]);
            end
            stop(`EITMR_T8_RUN_CTRL);
        end
        // Timer 9 toggle, stop, resume and count clear
        chk("toggle at rest", tog9, 32'h0);
        xfer(1'b1, `EITMR_T9_CMP, 32'h3);
        xfer(1'b1, `EITMR_T9_CFG, `EITMR_CS_HIGH);
        xfer(1'b1, `EITMR_T9_RUN_CTRL, 32'h1);
        wirq(1, 300, t1);
        repeat (10) @(posedge pclk);
        g = tog9;
        wirq(1, 300, t2);
        repeat (10) @(posedge pclk);
        chk("toggle inverts", tog9, {31'h0, ~g});
        chk("period", t2 - t1, 32);
        stop(`EITMR_T9_RUN_CTRL);
        // Output clear passes through three register stages
        repeat (3) @(posedge pclk);
        chk("toggle stopped", tog9, 32'h0);
        xfer(1'b0, `EITMR_T9_CNT, 32'h0);
        t3 = rd;
        xfer(1'b1, `EITMR_T9_RUN_CTRL, 32'h1);
        xfer(1'b0, `EITMR_T9_CNT, 32'h0);
        chk("count kept", rd, t3);
        stop(`EITMR_T9_RUN_CTRL);
        xfer(1'b1, `EITMR_T9_CNT, 32'h55);
        xfer(1'b0, `EITMR_T9_CNT, 32'h0);
        chk("count cleared", rd, 32'h0);
        // One-shot on timer A
        xfer(1'b1, `EITMR_TA_CFG, 32'h81);
        xfer(1'b1, `EITMR_TA_CMP, 32'h2);
        xfer(1'b1, `EITMR_TA_RUN_CTRL, 32'h1);
        wirq(2, 300, t1);
        xfer(1'b0, `EITMR_TA_RUN_CTRL, 32'h0);
        chk("one-shot run", rd[0], 32'h0);
        stop(`EITMR_TA_RUN_CTRL);
        // Cascade A into B, upper run bit left at zero
        xfer(1'b1, `EITMR_TA_CFG, 32'h05);
        xfer(1'b1, `EITMR_TA_CMP, 32'h1);
        xfer(1'b1, `EITMR_TB_CNT, 32'h0);
        xfer(1'b1, `EITMR_TA_RUN_CTRL, 32'h1);
        wirq(2, 150, t1);
        chk("lower interrupt", t1, 32'hFFFFFFFF);
        xfer(1'b0, `EITMR_TB_RUN_CTRL, 32'h0);
        chk("upper status", rd, 32'h0);
        xfer(1'b0, `EITMR_TB_CNT, 32'h0);
        chk("upper counts", rd != 32'h0, 32'h1);
        stop(`EITMR_TA_RUN_CTRL);
        conclude;
    end
endmodule // tb
`default_nettype wire
